/* logic/switch_engine_defines.svh */
// Constants for the switch engine core
`ifndef SWITCH_ENGINE_DEFINES_SVH
`define SWITCH_ENGINE_DEFINES_SVH

// ----------------------------------------
// Mailbox layout and command codes
// ----------------------------------------
`define MBOX_ADDR      24'h000000
`define MBOX_DATA_ADDR 24'h000001
`define MBOX_RESP_ADDR 24'h000040
`define CMD_WR_REG     8'h20
`define CMD_RD_REG     8'h40
`define CMD_TX_PKT     8'h60
`define CMD_TYPE_HI    31
`define CMD_TYPE_LO    24

// ----------------------------------------
// Port numbering
// ----------------------------------------
`define FAST_PORT_LO   5'h18
`define HOST_PORT      5'h1a
`define ENGINE_PORT    8'h1b
`define AGE_REG        8'h00

// ----------------------------------------
// Frame header and learning tables
// ----------------------------------------
`define DA_BYTES       4'h6
`define HDR_BYTES      4'hc
`define TBL_BASE       24'h100000
`define TBL_STRIDE     24'h040000
`define LINK_OFS       24'h020000
`define TBL_CUR_RST    2'h0
`define TBL_NXT_RST    2'h1
`define TBL_EMP_RST    2'h2

`endif

/* logic/switch_engine_pkg.sv */
// Types shared by the switch engine core
`default_nettype none
package switch_engine_pkg;

	typedef enum logic [3:0] {
		BS_IDLE  = 4'b0001,
		BS_SETUP = 4'b0010,
		BS_BURST = 4'b0100,
		BS_HOST  = 4'b1000
	} bus_state_t;

	typedef enum logic [5:0] {
		MB_IDLE  = 6'b000001,
		MB_FETCH = 6'b000010,
		MB_DATA  = 6'b000100,
		MB_EXEC  = 6'b001000,
		MB_RESP  = 6'b010000,
		MB_DONE  = 6'b100000
	} mbox_state_t;

	typedef enum logic [2:0] {
		OWN_NONE = 3'h0,
		OWN_LU   = 3'h1,
		OWN_PORT = 3'h2,
		OWN_MBOX = 3'h3,
		OWN_HDR  = 3'h4,
		OWN_HOST = 3'h5
	} owner_t;

endpackage
`default_nettype wire

/* logic/switch_engine_core.sv */
// Switch engine core: bus arbiter, memory control, mailbox, lookup and table rotation
// Contract
// - Store-and-forward packets are buffered in SDRAM, queued, read back, transmitted.
// - Cut-through routes ingress to egress directly, still storing an SDRAM copy.
// - Switching bus is 32 bits wide on the system clock, reaching all blocks.
// - Only the 32 data lines leave the chip; control stays internal.
// - Line buffer drives the external segment only during own SDRAM transfers; code also drives it for the host header strobe.
// - Both segments are one resource; no new operation while one is active.
// - Lookup and learning requests outrank packet receive and transmit.
// - Fast ports outrank slow ports; host bus request is lowest of all.
// - Memory control alone services every SDRAM read and write request.
// - Host writes mailbox, bridge raises command ready, device fetches command.
// - Device writes response into mailbox, then signals command complete.
// - Host-bound packet stored in ingress buffer; header strobe with identifying data.
// - Host transmit command queues packet at destination like network traffic.
// - Destination address extracted from first 6 bytes of unicast frames for lookup.
// - Lookup result puts ingress and egress port numbers on switching bus.
// - Three identical learning tables, each paired with its own link table.
// - Lookup uses Current, learning writes Current and Next, Empty held cleared.
// - Aging command rotates: Current to Empty, Next to Current, Empty to Next.
// - Every packet source learned into Current, then repeated into Next.
// - Addresses stored as linked lists from learning table into link table.
// - Mailbox command top byte: 0x20 write, 0x40 read, 0x60 transmit with address.
// - Ports 0-23 slow, 24-25 fast, 26 host; numbers used on the bus.
`timescale 1ns/1ps
`default_nettype none
`include "switch_engine_defines.svh"

module switch_engine_core (
	input  wire logic                                clk_in,
	input  wire logic                                rst_n_in,
	input  wire logic [25:0]                         port_req_in,
	input  wire logic                                lu_req_in,
	input  wire logic [23:0]                         req_addr_in,
	input  wire logic [7:0]                          req_len_in,
	input  wire logic                                req_write_in,
	input  wire logic [31:0]                         req_wdata_in,
	input  wire logic [31:0]                         ext_data_in,
	input  wire logic                                host_bus_request_in,
	input  wire logic                                mailbox_command_ready_in,
	input  wire logic [31:0]                         reg_rd_data_in,
	input  wire logic                                rx_frame_start_in,
	input  wire logic                                rx_byte_valid_in,
	input  wire logic [7:0]                          rx_byte_in,
	input  wire logic                                lookup_done_in,
	input  wire logic [4:0]                          lu_ingress_in,
	input  wire logic [4:0]                          lu_egress_in,
	input  wire logic                                cut_through_in,
	input  wire logic                                learn_done_in,
	output logic [25:0]                              grant_port_out,
	output logic                                     grant_lu_out,
	output logic                                     host_bus_grant_out,
	output logic                                     mem_start_out,
	output logic                                     mem_we_out,
	output logic [23:0]                              mem_addr_out,
	output logic [8:0]                               mem_len_out,
	output logic                                     data_strobe_out,
	output logic [31:0]                              ext_data_out,
	output logic                                     ext_data_oe_out,
	output logic [31:0]                              sw_data_out,
	output logic                                     sw_valid_out,
	output logic                                     lookup_notice_out,
	output logic                                     fwd_direct_out,
	output logic                                     fwd_queue_out,
	output logic                                     host_header_strobe_out,
	output logic                                     command_complete_out,
	output logic                                     reg_wr_out,
	output logic                                     reg_rd_out,
	output logic [7:0]                               reg_port_out,
	output logic [7:0]                               reg_index_out,
	output logic [31:0]                              reg_wdata_out,
	output logic                                     host_tx_queue_out,
	output logic [23:0]                              host_tx_addr_out,
	output logic                                     lu_start_out,
	output logic [47:0]                              lu_dest_mac_out,
	output logic [47:0]                              lu_src_mac_out,
	output logic                                     learn_start_out,
	output logic [1:0]                               learn_table_out,
	output logic [1:0]                               current_table_out,
	output logic [1:0]                               next_table_out,
	output logic [1:0]                               empty_table_out,
	output logic [23:0]                              lookup_base_out,
	output logic [23:0]                              lookup_link_base_out,
	output logic                                     clear_start_out,
	output logic [1:0]                               clear_table_out
);
	import switch_engine_pkg::*;

	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		logic mb_s1, mb_s2, mb_prev, hr_s1, hr_s2;
		bus_state_t bus_st;
		owner_t owner;
		logic [25:0] gport;
		logic glu, ghost;
		logic [23:0] addr;
		logic [8:0] cnt;
		logic write;
		logic mem_start, dstrobe;
		logic [31:0] ext_data;
		logic ext_oe;
		logic [31:0] sw_data;
		logic sw_valid, notice, direct, fqueue;
		logic hdr_pend, hstrobe;
		logic [31:0] hdr_word;
		mbox_state_t mb_st;
		logic mb_go;
		logic [31:0] mb_cmd, mb_resp;
		logic [8:0] mb_widx;
		logic complete, reg_wr, reg_rd;
		logic [7:0] reg_port, reg_index;
		logic [31:0] reg_wdata;
		logic txq;
		logic [23:0] tx_addr;
		logic [3:0] bcnt;
		logic [47:0] dst, src;
		logic lu_start, learn_start, learn_ph;
		logic [1:0] learn_tbl, cur, nxt, emp, clr_tbl;
		logic [23:0] cur_base, cur_link;
		logic rot, clr_start;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	// Lowest set bit; inputs are never all zero when used
	function automatic logic [4:0] first_one(input logic [25:0] v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = 25; i >= 0; i--)
		begin
			if (v[i])
				idx = 5'(i);
		end
		return idx;
	endfunction

	// Learning table base, or its linked overflow table
	function automatic logic [23:0] tbl_base(input logic [1:0] t, input logic link);
		logic [23:0] b;
		b = `TBL_BASE + 24'(t) * `TBL_STRIDE;
		return link ? b + `LINK_OFS : b;
	endfunction

	logic [25:0] fast_req;
	logic [25:0] slow_req;
	logic        mb_req;
	assign fast_req = port_req_in & {2'b11, 24'h000000};
	assign slow_req = port_req_in & {2'b00, 24'hffffff};
	assign mb_req = (st_ff.mb_st == MB_FETCH || st_ff.mb_st == MB_DATA
		|| st_ff.mb_st == MB_RESP) && !st_ff.mb_go;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		// Bridge pins come from another domain
		nxt_st.mb_s1 = mailbox_command_ready_in;
		nxt_st.mb_s2 = st_ff.mb_s1;
		nxt_st.mb_prev = st_ff.mb_s2;
		nxt_st.hr_s1 = host_bus_request_in;
		nxt_st.hr_s2 = st_ff.hr_s1;
		nxt_st.gport = 26'h0000000;
		nxt_st.glu = 1'b0;
		nxt_st.mem_start = 1'b0;
		nxt_st.dstrobe = 1'b0;
		nxt_st.ext_oe = 1'b0;
		nxt_st.sw_valid = 1'b0;
		nxt_st.notice = 1'b0;
		nxt_st.direct = 1'b0;
		nxt_st.fqueue = 1'b0;
		nxt_st.hstrobe = 1'b0;
		nxt_st.complete = 1'b0;
		nxt_st.reg_wr = 1'b0;
		nxt_st.reg_rd = 1'b0;
		nxt_st.txq = 1'b0;
		nxt_st.lu_start = 1'b0;
		nxt_st.learn_start = 1'b0;
		nxt_st.rot = 1'b0;
		nxt_st.clr_start = 1'b0;

		// ----------------------------------------
		// Arbiter and memory control
		// ----------------------------------------
		case (st_ff.bus_st)
			BS_IDLE:
			begin
				// Grants only from idle, so segments never overlap
				if (lu_req_in)
				begin
					nxt_st.glu = 1'b1;
					nxt_st.owner = OWN_LU;
					nxt_st.bus_st = BS_SETUP;
				end
				else if (|fast_req)
				begin
					nxt_st.gport[first_one(fast_req)] = 1'b1;
					nxt_st.owner = OWN_PORT;
					nxt_st.bus_st = BS_SETUP;
				end
				else if (|slow_req)
				begin
					nxt_st.gport[first_one(slow_req)] = 1'b1;
					nxt_st.owner = OWN_PORT;
					nxt_st.bus_st = BS_SETUP;
				end
				else if (st_ff.hdr_pend)
				begin
					nxt_st.hdr_pend = 1'b0;
					nxt_st.owner = OWN_HDR;
					nxt_st.ext_data = st_ff.hdr_word;
					nxt_st.ext_oe = 1'b1;
					nxt_st.hstrobe = 1'b1;
				end
				else if (mb_req)
				begin
					nxt_st.mb_go = 1'b1;
					nxt_st.owner = OWN_MBOX;
					nxt_st.bus_st = BS_SETUP;
					nxt_st.write = (st_ff.mb_st == MB_RESP);
					nxt_st.cnt = 9'h001;
					nxt_st.addr = `MBOX_ADDR;
					if (st_ff.mb_st == MB_DATA)
					begin
						nxt_st.addr = `MBOX_DATA_ADDR;
						nxt_st.cnt = {1'b0, st_ff.mb_cmd[7:0]};
					end
					else if (st_ff.mb_st == MB_RESP)
						nxt_st.addr = `MBOX_RESP_ADDR;
				end
				else if (st_ff.hr_s2)
				begin
					nxt_st.ghost = 1'b1;
					nxt_st.owner = OWN_HOST;
					nxt_st.bus_st = BS_HOST;
				end
			end
			BS_SETUP:
			begin
				if (st_ff.owner != OWN_MBOX)
				begin
					nxt_st.addr = req_addr_in;
					nxt_st.cnt = {1'b0, req_len_in};
					nxt_st.write = req_write_in;
				end
				nxt_st.mem_start = 1'b1;
				nxt_st.bus_st = BS_BURST;
			end
			BS_BURST:
			begin
				nxt_st.cnt = st_ff.cnt - 9'h001;
				nxt_st.dstrobe = 1'b1;
				if (st_ff.write)
				begin
					// Drive outward only for own SDRAM writes
					nxt_st.ext_oe = 1'b1;
					nxt_st.ext_data = (st_ff.owner == OWN_MBOX) ?
						st_ff.mb_resp : req_wdata_in;
				end
				else
				begin
					nxt_st.sw_data = ext_data_in;
					nxt_st.sw_valid = 1'b1;
					if (st_ff.owner == OWN_MBOX && st_ff.mb_st == MB_FETCH)
					begin
						nxt_st.mb_cmd = ext_data_in;
						nxt_st.reg_port = ext_data_in[23:16];
						nxt_st.reg_index = ext_data_in[15:8];
					end
					else if (st_ff.owner == OWN_MBOX)
					begin
						nxt_st.reg_wr = 1'b1;
						nxt_st.reg_wdata = ext_data_in;
						nxt_st.reg_index = 8'(st_ff.mb_cmd[15:8] + st_ff.mb_widx[7:0]);
						nxt_st.mb_widx = st_ff.mb_widx + 9'h001;
					end
				end
				if (st_ff.cnt <= 9'h001)
				begin
					nxt_st.bus_st = BS_IDLE;
					nxt_st.owner = OWN_NONE;
					if (st_ff.owner == OWN_MBOX)
					begin
						nxt_st.mb_go = 1'b0;
						nxt_st.mb_widx = 9'h000;
						if (st_ff.mb_st == MB_FETCH && ext_data_in[31:24] == `CMD_WR_REG
							&& ext_data_in[7:0] != 8'h00)
							nxt_st.mb_st = MB_DATA;
						else if (st_ff.mb_st == MB_RESP)
							nxt_st.mb_st = MB_DONE;
						else
							nxt_st.mb_st = MB_EXEC;
					end
				end
			end
			BS_HOST:
			begin
				// Host keeps the external segment until it drops its request
				if (!st_ff.hr_s2)
				begin
					nxt_st.ghost = 1'b0;
					nxt_st.owner = OWN_NONE;
					nxt_st.bus_st = BS_IDLE;
				end
			end
			default:
			begin
				nxt_st.bus_st = BS_IDLE;
				nxt_st.owner = OWN_NONE;
				nxt_st.ghost = 1'b0;
			end
		endcase

		// ----------------------------------------
		// Mailbox command sequencing
		// ----------------------------------------
		case (st_ff.mb_st)
			MB_IDLE:
			begin
				if (st_ff.mb_s2 && !st_ff.mb_prev)
					nxt_st.mb_st = MB_FETCH;
			end
			MB_EXEC:
			begin
				nxt_st.mb_resp = st_ff.mb_cmd;
				nxt_st.mb_st = MB_RESP;
				case (st_ff.mb_cmd[`CMD_TYPE_HI:`CMD_TYPE_LO])
					`CMD_WR_REG:
					begin
						if (st_ff.reg_port == `ENGINE_PORT && st_ff.reg_index == `AGE_REG)
							nxt_st.rot = 1'b1;
					end
					`CMD_RD_REG:
						nxt_st.reg_rd = 1'b1;
					`CMD_TX_PKT:
					begin
						nxt_st.txq = 1'b1;
						nxt_st.tx_addr = st_ff.mb_cmd[23:0];
					end
					default:
						nxt_st.mb_resp = st_ff.mb_cmd;
				endcase
			end
			MB_RESP:
			begin
				if (st_ff.reg_rd)
					nxt_st.mb_resp = reg_rd_data_in;
			end
			MB_DONE:
			begin
				nxt_st.complete = 1'b1;
				nxt_st.mb_st = MB_IDLE;
			end
			MB_FETCH, MB_DATA:
			begin
				// Left to the burst end above, which picks the next step
			end
			default:
				nxt_st.mb_st = MB_IDLE;
		endcase

		// ----------------------------------------
		// Table rotation on aging
		// ----------------------------------------
		if (st_ff.rot)
		begin
			nxt_st.cur = st_ff.nxt;
			nxt_st.nxt = st_ff.emp;
			nxt_st.emp = st_ff.cur;
			nxt_st.cur_base = tbl_base(st_ff.nxt, 1'b0);
			nxt_st.cur_link = tbl_base(st_ff.nxt, 1'b1);
			nxt_st.clr_start = 1'b1;
			nxt_st.clr_tbl = st_ff.cur;
		end

		// ----------------------------------------
		// Header capture, lookup and learning
		// ----------------------------------------
		if (rx_frame_start_in)
			nxt_st.bcnt = 4'h0;
		else if (rx_byte_valid_in && st_ff.bcnt < `HDR_BYTES)
		begin
			nxt_st.bcnt = st_ff.bcnt + 4'h1;
			if (st_ff.bcnt < `DA_BYTES)
				nxt_st.dst = {st_ff.dst[39:0], rx_byte_in};
			else
				nxt_st.src = {st_ff.src[39:0], rx_byte_in};
			if (st_ff.bcnt == `HDR_BYTES - 4'h1)
			begin
				// Group bit set means no learned destination to find
				nxt_st.lu_start = !st_ff.dst[40];
				nxt_st.learn_start = 1'b1;
				nxt_st.learn_tbl = st_ff.cur;
				nxt_st.learn_ph = 1'b0;
			end
		end
		if (learn_done_in && !st_ff.learn_ph)
		begin
			nxt_st.learn_start = 1'b1;
			nxt_st.learn_tbl = st_ff.nxt;
			nxt_st.learn_ph = 1'b1;
		end
		if (lookup_done_in)
		begin
			nxt_st.sw_data = {19'h00000, lu_ingress_in, 3'h0, lu_egress_in};
			nxt_st.notice = 1'b1;
			// Fast ports always store and forward
			nxt_st.direct = cut_through_in && lu_ingress_in < `FAST_PORT_LO
				&& lu_egress_in < `FAST_PORT_LO;
			nxt_st.fqueue = lu_egress_in != `HOST_PORT;
			if (lu_egress_in == `HOST_PORT)
			begin
				// Set wins over the arbiter's clear
				nxt_st.hdr_pend = 1'b1;
				nxt_st.hdr_word = {19'h00000, lu_ingress_in, 3'h0, lu_egress_in};
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_ff <= '0;
			st_ff.bus_st <= BS_IDLE;
			st_ff.mb_st <= MB_IDLE;
			st_ff.owner <= OWN_NONE;
			st_ff.cur <= `TBL_CUR_RST;
			st_ff.nxt <= `TBL_NXT_RST;
			st_ff.emp <= `TBL_EMP_RST;
			st_ff.cur_base <= `TBL_BASE;
			st_ff.cur_link <= `TBL_BASE + `LINK_OFS;
		end
		else
			st_ff <= nxt_st;
	end

	assign grant_port_out = st_ff.gport;
	assign grant_lu_out = st_ff.glu;
	assign host_bus_grant_out = st_ff.ghost;
	assign mem_start_out = st_ff.mem_start;
	assign mem_we_out = st_ff.write;
	assign mem_addr_out = st_ff.addr;
	assign mem_len_out = st_ff.cnt;
	assign data_strobe_out = st_ff.dstrobe;
	assign ext_data_out = st_ff.ext_data;
	assign ext_data_oe_out = st_ff.ext_oe;
	assign sw_data_out = st_ff.sw_data;
	assign sw_valid_out = st_ff.sw_valid;
	assign lookup_notice_out = st_ff.notice;
	assign fwd_direct_out = st_ff.direct;
	assign fwd_queue_out = st_ff.fqueue;
	assign host_header_strobe_out = st_ff.hstrobe;
	assign command_complete_out = st_ff.complete;
	assign reg_wr_out = st_ff.reg_wr;
	assign reg_rd_out = st_ff.reg_rd;
	assign reg_port_out = st_ff.reg_port;
	assign reg_index_out = st_ff.reg_index;
	assign reg_wdata_out = st_ff.reg_wdata;
	assign host_tx_queue_out = st_ff.txq;
	assign host_tx_addr_out = st_ff.tx_addr;
	assign lu_start_out = st_ff.lu_start;
	assign lu_dest_mac_out = st_ff.dst;
	assign lu_src_mac_out = st_ff.src;
	assign learn_start_out = st_ff.learn_start;
	assign learn_table_out = st_ff.learn_tbl;
	assign current_table_out = st_ff.cur;
	assign next_table_out = st_ff.nxt;
	assign empty_table_out = st_ff.emp;
	assign lookup_base_out = st_ff.cur_base;
	assign lookup_link_base_out = st_ff.cur_link;
	assign clear_start_out = st_ff.clr_start;
	assign clear_table_out = st_ff.clr_tbl;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_idle_lu;
		st_ff.bus_st == BS_IDLE && lu_req_in;
	endsequence
	sequence s_mb_last;
		st_ff.bus_st == BS_BURST && st_ff.owner == OWN_MBOX
			&& st_ff.mb_st == MB_RESP && st_ff.cnt == 9'h001;
	endsequence

	property p_oe_own;
		ext_data_oe_out |-> !host_bus_grant_out && st_ff.owner != OWN_HOST;
	endproperty
	a_oe_own: assert property (p_oe_own) else $error("line buffer on for host");
	property p_one_owner;
		$onehot0({|grant_port_out, grant_lu_out, host_bus_grant_out});
	endproperty
	a_one_owner: assert property (p_one_owner) else $error("two bus owners");
	property p_lu_first;
		s_idle_lu |=> grant_lu_out && grant_port_out == 26'h0000000;
	endproperty
	a_lu_first: assert property (p_lu_first) else $error("lookup not first");
	property p_fast_first;
		st_ff.bus_st == BS_IDLE && !lu_req_in && |port_req_in[25:24]
			|=> |grant_port_out[25:24];
	endproperty
	a_fast_first: assert property (p_fast_first) else $error("slow port won");
	property p_host_last;
		st_ff.bus_st == BS_IDLE && (lu_req_in || |port_req_in) |=> !$rose(host_bus_grant_out);
	endproperty
	a_host_last: assert property (p_host_last) else $error("host not lowest");
	property p_complete;
		s_mb_last |=> ##1 command_complete_out;
	endproperty
	a_complete: assert property (p_complete) else $error("no completion");
	property p_hdr;
		host_header_strobe_out |-> ext_data_oe_out && ext_data_out[4:0] == `HOST_PORT;
	endproperty
	a_hdr: assert property (p_hdr) else $error("header strobe without data");
	property p_notice;
		lookup_done_in |=> lookup_notice_out && sw_data_out[4:0] == $past(lu_egress_in)
			&& sw_data_out[12:8] == $past(lu_ingress_in);
	endproperty
	a_notice: assert property (p_notice) else $error("ports not on bus");
	property p_rotate;
		st_ff.rot |=> current_table_out == $past(next_table_out)
			&& empty_table_out == $past(current_table_out) && clear_start_out;
	endproperty
	a_rotate: assert property (p_rotate) else $error("bad table rotation");
	property p_da;
		lu_start_out |-> $past(st_ff.bcnt) == `HDR_BYTES - 4'h1;
	endproperty
	a_da: assert property (p_da) else $error("lookup start off header");

endmodule

`default_nettype wire

/* tb/bridge_model.sv */
// Bus bridge model: host mailbox in SDRAM and host bus request
`timescale 1ns/1ps
`default_nettype none
module bridge_model (
	input wire logic        clk_in,
	input wire logic        mem_start_out,
	input wire logic        mem_we_out,
	input wire logic [23:0] mem_addr_out,
	input wire logic        data_strobe_out,
	input wire logic [31:0] ext_data_out,
	input wire logic        host_bus_grant_out,
	input wire logic        command_complete_out,
	output logic [31:0]     ext_data_in,
	output logic            host_bus_request_in = 1'b0,
	output logic            mailbox_command_ready_in = 1'b0
);
	logic [31:0] mem [0:127];
	logic [31:0] last = '0;
	logic [6:0]  wp;
	// Single-word reads only; an idle bus toggles so stale data never looks valid
	assign ext_data_in = (mem_start_out && !mem_we_out) ? mem[mem_addr_out[6:0]] : ~last;
	always @(posedge clk_in)
	begin
		last <= ext_data_in;
		if (data_strobe_out && mem_we_out)
			mem[wp] <= ext_data_out;
		wp <= mem_start_out ? mem_addr_out[6:0] : wp + {6'h0, data_strobe_out};
	end
	// Host holds the bus only while it fills the mailbox
	task automatic host_cmd(input logic [31:0] cmd, input logic [31:0] dat);
		@(negedge clk_in);
		host_bus_request_in = 1'b1;
		for (int n = 0; n < 300 && host_bus_grant_out !== 1'b1; n++) @(negedge clk_in);
		mem[0] = cmd;
		mem[1] = dat;
		host_bus_request_in = 1'b0;
		for (int n = 0; n < 300 && host_bus_grant_out !== 1'b0; n++) @(negedge clk_in);
		mailbox_command_ready_in = 1'b1;
		for (int n = 0; n < 900 && command_complete_out !== 1'b1; n++) @(negedge clk_in);
		mailbox_command_ready_in = 1'b0;
	endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the switch engine core
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_in = 1'b0, rst_n_in = 1'b0, lu_req_in = 1'b0, req_write_in = 1'b0;
	logic rx_frame_start_in = 1'b0, rx_byte_valid_in = 1'b0, lookup_done_in = 1'b0;
	logic cut_through_in = 1'b0, learn_done_in = 1'b0, host_bus_request_in;
	logic mailbox_command_ready_in, grant_lu_out, host_bus_grant_out, mem_start_out;
	logic mem_we_out, data_strobe_out, ext_data_oe_out, sw_valid_out, lookup_notice_out;
	logic fwd_direct_out, fwd_queue_out, host_header_strobe_out, command_complete_out;
	logic reg_wr_out, reg_rd_out, host_tx_queue_out, lu_start_out, learn_start_out;
	logic clear_start_out;
	logic [25:0] port_req_in = '0, grant_port_out;
	logic [23:0] req_addr_in = '0, mem_addr_out, host_tx_addr_out, lookup_base_out;
	logic [23:0] lookup_link_base_out;
	logic [7:0]  req_len_in = '0, rx_byte_in = '0, reg_port_out, reg_index_out;
	logic [31:0] req_wdata_in = '0, reg_rd_data_in = '0, ext_data_in, ext_data_out;
	logic [31:0] sw_data_out, reg_wdata_out;
	logic [4:0]  lu_ingress_in = '0, lu_egress_in = '0;
	logic [8:0]  mem_len_out;
	logic [47:0] lu_dest_mac_out, lu_src_mac_out;
	logic [1:0]  learn_table_out, current_table_out, next_table_out, empty_table_out;
	logic [1:0]  clear_table_out;
	logic [7:0]  pv;
	int          bad_count = 0;
	int          checked = 0;
	logic [31:0] wr_n = '0, rd_n = '0, tx_n = '0;
	assign pv = {data_strobe_out & mem_we_out, |grant_port_out, grant_lu_out, lookup_notice_out,
		host_header_strobe_out, lu_start_out, learn_start_out, command_complete_out};
	switch_engine_core uut (.*);
	bridge_model bb (.*);
	// Pulse tallies, so that single-cycle strobes cannot slip past
	always @(negedge clk_in)
	begin
		wr_n <= wr_n + 32'(reg_wr_out);
		rd_n <= rd_n + 32'(reg_rd_out);
		tx_n <= tx_n + 32'(host_tx_queue_out);
	end
	initial forever #2 clk_in = ~clk_in;
	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic await(input int i);
		@(negedge clk_in);
		for (int n = 0; n < 900 && pv[i] !== 1'b1; n++) @(negedge clk_in);
		chk(pv[i], 1'b1);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic mb(input logic [31:0] cmd);
		fork
			bb.host_cmd(cmd, 32'h1);
			await(0);
		join
	endtask
	task automatic t_arb();
		port_req_in = 26'h2000008;
		lu_req_in = 1'b1;
		await(5);
		chk(grant_port_out, 26'h0);
		lu_req_in = 1'b0;
		await(6);
		chk(grant_port_out, 26'h2000000);
		port_req_in = 26'h0000008;
		await(6);
		port_req_in = '0;
		req_write_in = 1'b1;
		req_wdata_in = 32'h5a5a0003;
		chk(grant_port_out, 26'h0000008);
		await(7);
		req_write_in = 1'b0;
		chk({ext_data_oe_out, ext_data_out}, {1'b1, 32'h5a5a0003});
	endtask
	task automatic t_mbox();
		for (int k = 0; k < 2; k++)
		begin
			mb(32'h201b0001);
			chk({reg_port_out, reg_index_out, reg_wdata_out}, {16'h1b00, 32'h1});
			chk({current_table_out, next_table_out}, {2'((k + 1) % 3), 2'((k + 2) % 3)});
			chk({empty_table_out, clear_table_out}, {2'(k), 2'(k)});
			chk(lookup_base_out, 24'h100000 + 24'h40000 * 24'((k + 1) % 3));
			chk(lookup_link_base_out, 24'h120000 + 24'h40000 * 24'((k + 1) % 3));
			chk({mem_we_out, mem_addr_out}, {1'b1, 24'h000040});
		end
		reg_rd_data_in = 32'hc0ffee01;
		mb(32'h40050101);
		chk({reg_port_out, bb.mem[64]}, {8'h05, 32'hc0ffee01});
		mb(32'h6000abcd);
		chk(host_tx_addr_out, 24'h00abcd);
		chk({wr_n, rd_n, tx_n}, {32'h2, 32'h1, 32'h1});
	endtask
	task automatic t_lookup(input logic [4:0] eg, input logic ct);
		lu_ingress_in = 5'h03;
		lu_egress_in = eg;
		cut_through_in = ct;
		lookup_done_in = 1'b1;
		await(4);
		lookup_done_in = 1'b0;
		chk({sw_data_out, fwd_direct_out, fwd_queue_out}, {19'h0, 5'h03, 3'h0, eg, ct, eg != 5'h1a});
	endtask
	task automatic t_frame();
		logic [95:0] f;
		f = 96'h021122334455_0a0b0c0d0e0f;
		rx_frame_start_in = 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			@(negedge clk_in);
			rx_frame_start_in = 1'b0;
			rx_byte_valid_in = 1'b1;
			rx_byte_in = f[95 - 8 * i -: 8];
		end
		await(2);
		rx_byte_valid_in = 1'b0;
		learn_done_in = 1'b1;
		chk({lu_dest_mac_out, lu_src_mac_out}, f);
		chk(learn_table_out, 2'h2);
		await(1);
		learn_done_in = 1'b0;
		chk(learn_table_out, 2'h0);
	endtask
	initial
	begin
		repeat (10) @(negedge clk_in);
		rst_n_in = 1'b1;
		chk({current_table_out, next_table_out, empty_table_out}, 6'h06);
		t_arb();
		t_mbox();
		t_lookup(5'h05, 1'b1);
		t_lookup(5'h1a, 1'b0);
		await(3);
		chk({ext_data_oe_out, ext_data_out}, {1'b1, 19'h0, 5'h03, 3'h0, 5'h1a});
		t_frame();
		tally_and_finish();
	end
	// Far beyond the hundred or so cycles the scenarios need
	initial
	begin
		#40000;
		bad_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
